// File: core/drive_ctrl_pkg.sv
// constants and types for the drive command/status word interpreter
// assumes a single 250 MHz drive clock and an APB register port
package drive_ctrl_pkg;
  localparam int WORD_W = 16;
  // command word bit positions
  localparam int CMD_ON = 0;
  localparam int CMD_NO_COAST = 1;
  localparam int CMD_NO_QUICK = 2;
  localparam int CMD_ENABLE_OP = 3;
  localparam int CMD_RG_ENABLE = 4;
  localparam int CMD_RG_RUN = 5;
  localparam int CMD_SP_ENABLE = 6;
  localparam int CMD_FAULT_ACK = 7;
  localparam int CMD_JOG_CW = 8;
  localparam int CMD_JOG_CCW = 9;
  localparam int CMD_MASTER_CTRL = 10;
  localparam int CMD_SP_INVERT = 11;
  localparam int CMD_DATA_SET0 = 15;
  // status word bit positions
  localparam int STS_READY_START = 0;
  localparam int STS_READY = 1;
  localparam int STS_OP_EN = 2;
  localparam int STS_FAULT = 3;
  localparam int STS_NO_COAST = 4;
  localparam int STS_NO_QUICK = 5;
  localparam int STS_SWON_DIS = 6;
  // register byte offsets and timeout reset value
  localparam logic [11:0] REG_TIMEOUT = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_COMMAND = 12'h008;
  localparam logic [15:0] TIMEOUT_RST = 16'h0000;
  // status register fields beyond the status word
  localparam int SREG_STATE_LSB = 16;
  localparam int SREG_FAULT = 20;
  localparam int SREG_TMO_FAULT = 21;
  // timing
  localparam int MS_IN_NS = 1000000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
  localparam int MS_CNT_W = 18;
  // deceleration modes
  localparam logic [1:0] DECEL_NORMAL = 2'h0;
  localparam logic [1:0] DECEL_RAMP = 2'h1;
  localparam logic [1:0] DECEL_FASTEST = 2'h2;

  typedef enum logic [2:0] {
    ST_INHIBIT,
    ST_READY_START,
    ST_SWITCHED_ON,
    ST_OPERATING,
    ST_RAMPDOWN,
    ST_QUICKSTOP,
    ST_FAULT
  } drive_state_e;
endpackage

// File: core/drive_control_status_word_logic.sv
// drive command word interpreter and status word builder
// assumes telegram words arrive synchronous to i_mclk with a one-cycle valid
`timescale 1ns/1ps
module drive_control_status_word_logic
  import drive_ctrl_pkg::*;
#(
  parameter int unsigned P_CYCLES_PER_MS = CYCLES_PER_MS
) (
  input wire logic i_mclk, // drive clock
  input wire logic i_reset, // async reset, high
  input wire logic i_telegram_valid, // one-cycle telegram strobe
  input wire logic [WORD_W-1:0] i_command_word, // received command word
  input wire logic [WORD_W-1:0] i_setpoint_word, // received speed setpoint
  input wire logic i_supply_ok, // power supply present
  input wire logic i_init_done, // electronics initialised
  input wire logic i_fault_active, // power stage fault level
  input wire logic i_below_min_freq, // output frequency below minimum
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  input wire logic [3:0] i_pstrb, // apb byte strobes
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error
  output logic [WORD_W-1:0] o_status_word, // status word for reply
  output logic o_status_strobe, // fresh status pulse
  output logic o_pulse_enable, // output pulses enabled
  output logic [1:0] o_decel_mode, // deceleration mode
  output logic o_rg_enable, // ramp generator enabled
  output logic o_rg_reset, // ramp output forced to zero
  output logic o_rg_freeze, // ramp output frozen
  output logic [WORD_W-1:0] o_setpoint, // gated ramp input setpoint
  output logic o_jog_cw, // jog clockwise active
  output logic o_jog_ccw, // jog counter-clockwise active
  output logic o_reverse_dir, // direction reversed
  output logic o_data_set_sel, // command data set bit 0
  output logic o_process_data_valid, // master control valid
  output logic o_telegram_fault // telegram timeout fault
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    drive_state_e st;
    logic [WORD_W-1:0] cmd;
    logic ack_pulse;
    logic reply_pend;
    logic reply;
    logic [WORD_W-1:0] sp_raw;
    logic [WORD_W-1:0] sp_out;
    logic fault;
    logic tmo_fault;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic [WORD_W-1:0] ms_elapsed;
    logic [WORD_W-1:0] tmo_set;
    logic [WORD_W-1:0] status;
    logic pulse_en;
    logic [1:0] decel;
    logic rg_en;
    logic rg_reset;
    logic rg_freeze;
    logic jog_cw;
    logic jog_ccw;
    logic jog_brake;
    logic reverse;
    logic data_set;
    logic pd_valid;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctl_s;

  ctl_s s_r;
  ctl_s s_nxt;

  function automatic logic reg_mapped(input logic [11:0] addr);
    reg_mapped = (addr == REG_TIMEOUT) || (addr == REG_STATUS) || (addr == REG_COMMAND);
  endfunction

  function automatic logic [31:0] reg_read(input logic [11:0] addr, input ctl_s s);
    reg_read = 32'h0000_0000;
    if (addr == REG_TIMEOUT) begin
      reg_read[WORD_W-1:0] = s.tmo_set;
    end else if (addr == REG_STATUS) begin
      reg_read[WORD_W-1:0] = s.status;
      reg_read[SREG_STATE_LSB+2:SREG_STATE_LSB] = s.st;
      reg_read[SREG_FAULT] = s.fault;
      reg_read[SREG_TMO_FAULT] = s.tmo_fault;
    end else if (addr == REG_COMMAND) begin
      reg_read[WORD_W-1:0] = s.cmd;
    end
  endfunction

  logic accept;
  logic tmo_hit;
  logic ack_edge;
  logic jog_any;
  logic c_on, c_no_coast, c_no_quick, c_enop;

  assign c_on = s_r.cmd[CMD_ON];
  assign c_no_coast = s_r.cmd[CMD_NO_COAST];
  assign c_no_quick = s_r.cmd[CMD_NO_QUICK];
  assign c_enop = s_r.cmd[CMD_ENABLE_OP];
  // zero words never reach the drive, so they also never feed the watchdog
  assign accept = i_telegram_valid && (i_command_word != 16'h0000);
  assign ack_edge = i_command_word[CMD_FAULT_ACK] && !s_r.cmd[CMD_FAULT_ACK];
  assign tmo_hit = (s_r.tmo_set != 16'h0000) && (s_r.ms_elapsed >= s_r.tmo_set);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack_pulse = 1'b0;
    s_nxt.reply = s_r.reply_pend;
    s_nxt.reply_pend = 1'b0;

    // one consistent snapshot per telegram
    if (accept) begin
      s_nxt.cmd = i_command_word;
      s_nxt.reply_pend = 1'b1;
      s_nxt.ack_pulse = ack_edge;
      if (i_command_word[CMD_MASTER_CTRL]) begin
        s_nxt.sp_raw = i_setpoint_word;
      end
    end

    // telegram watchdog in whole milliseconds
    if (accept || s_r.tmo_set == 16'h0000) begin
      s_nxt.ms_cnt = '0;
      s_nxt.ms_elapsed = 16'h0000;
    end else if (!tmo_hit) begin
      if (s_r.ms_cnt == MS_CNT_W'(P_CYCLES_PER_MS - 1)) begin
        s_nxt.ms_cnt = '0;
        s_nxt.ms_elapsed = s_r.ms_elapsed + 16'h0001;
      end else begin
        s_nxt.ms_cnt = s_r.ms_cnt + {{(MS_CNT_W-1){1'b0}}, 1'b1};
      end
    end

    // set wins over the acknowledge clear
    if (s_r.ack_pulse && !i_fault_active && !tmo_hit) begin
      s_nxt.fault = 1'b0;
      s_nxt.tmo_fault = 1'b0;
    end
    if (tmo_hit) begin
      s_nxt.tmo_fault = 1'b1;
    end
    if (i_fault_active || tmo_hit) begin
      s_nxt.fault = 1'b1;
    end

    // state machine, stop priority coast > quick > ramp
    unique case (s_r.st)
      ST_INHIBIT: begin
        if (c_no_coast && c_no_quick && !c_on) begin
          s_nxt.st = ST_READY_START;
        end
      end
      ST_READY_START: begin
        if (!c_no_coast || !c_no_quick) begin
          s_nxt.st = ST_INHIBIT;
        end else if (c_on) begin
          s_nxt.st = ST_SWITCHED_ON;
        end
      end
      ST_SWITCHED_ON: begin
        if (!c_no_coast || !c_no_quick) begin
          s_nxt.st = ST_INHIBIT;
        end else if (!c_on) begin
          s_nxt.st = ST_READY_START;
        end else if (c_enop) begin
          s_nxt.st = ST_OPERATING;
        end
      end
      ST_OPERATING: begin
        if (!c_no_coast) begin
          s_nxt.st = ST_INHIBIT;
        end else if (!c_no_quick) begin
          s_nxt.st = ST_QUICKSTOP;
        end else if (!c_on) begin
          s_nxt.st = ST_RAMPDOWN;
        end else if (!c_enop) begin
          s_nxt.st = ST_SWITCHED_ON;
        end
      end
      ST_RAMPDOWN: begin
        if (!c_no_coast) begin
          s_nxt.st = ST_INHIBIT;
        end else if (!c_no_quick) begin
          s_nxt.st = ST_QUICKSTOP;
        end else if (!c_enop || i_below_min_freq) begin
          s_nxt.st = ST_READY_START;
        end
      end
      ST_QUICKSTOP: begin
        if (!c_no_coast || !c_enop || i_below_min_freq) begin
          s_nxt.st = ST_INHIBIT;
        end
      end
      ST_FAULT: begin
        if (s_r.ack_pulse && !i_fault_active && !tmo_hit) begin
          s_nxt.st = ST_INHIBIT;
        end
      end
    endcase
    // any fault outranks every command
    if (s_nxt.fault) begin
      s_nxt.st = ST_FAULT;
    end

    // jog only from standstill; both jog bits together cancel each other
    s_nxt.jog_cw = (s_nxt.st == ST_READY_START) && s_r.cmd[CMD_JOG_CW] && !s_r.cmd[CMD_JOG_CCW];
    s_nxt.jog_ccw = (s_nxt.st == ST_READY_START) && s_r.cmd[CMD_JOG_CCW] && !s_r.cmd[CMD_JOG_CW];
    jog_any = s_nxt.jog_cw || s_nxt.jog_ccw;
    if (jog_any || i_below_min_freq || s_nxt.st != ST_READY_START) begin
      s_nxt.jog_brake = 1'b0;
    end else if (s_r.jog_cw || s_r.jog_ccw) begin
      s_nxt.jog_brake = 1'b1;
    end

    s_nxt.pulse_en = jog_any || s_nxt.jog_brake ||
                     (c_enop && (s_nxt.st == ST_OPERATING || s_nxt.st == ST_RAMPDOWN ||
                                 s_nxt.st == ST_QUICKSTOP));

    if (s_nxt.st == ST_QUICKSTOP || s_nxt.jog_brake || !s_r.cmd[CMD_RG_ENABLE]) begin
      s_nxt.decel = DECEL_FASTEST;
    end else if (s_nxt.st == ST_RAMPDOWN) begin
      s_nxt.decel = DECEL_RAMP;
    end else begin
      s_nxt.decel = DECEL_NORMAL;
    end

    // ramp generator controls; bits 12 to 14 are deliberately unread
    s_nxt.rg_en = s_r.cmd[CMD_RG_ENABLE];
    s_nxt.rg_reset = !s_r.cmd[CMD_RG_ENABLE];
    s_nxt.rg_freeze = !s_r.cmd[CMD_RG_RUN];
    s_nxt.reverse = s_r.cmd[CMD_SP_INVERT];
    s_nxt.data_set = s_r.cmd[CMD_DATA_SET0];
    s_nxt.pd_valid = s_r.cmd[CMD_MASTER_CTRL];
    if (!s_r.cmd[CMD_SP_ENABLE]) begin
      s_nxt.sp_out = 16'h0000;
    end else if (s_r.cmd[CMD_SP_INVERT]) begin
      s_nxt.sp_out = ~s_r.sp_raw + 16'h0001;
    end else begin
      s_nxt.sp_out = s_r.sp_raw;
    end

    // status word tracks the next state so both flip at the same edge
    s_nxt.status = 16'h0000;
    s_nxt.status[STS_READY_START] = i_supply_ok && i_init_done && !s_nxt.pulse_en;
    s_nxt.status[STS_READY] = (s_nxt.st == ST_SWITCHED_ON) || (s_nxt.st == ST_OPERATING);
    s_nxt.status[STS_OP_EN] = (s_nxt.st == ST_OPERATING);
    s_nxt.status[STS_FAULT] = s_nxt.fault && (s_nxt.st != ST_OPERATING);
    s_nxt.status[STS_NO_COAST] = c_no_coast;
    s_nxt.status[STS_NO_QUICK] = c_no_quick;
    s_nxt.status[STS_SWON_DIS] = (s_nxt.st == ST_INHIBIT);

    // apb slave: one wait state, answer registered
    s_nxt.pready = i_psel && i_penable && !s_r.pready;
    s_nxt.pslverr = i_psel && i_penable && !s_r.pready && !reg_mapped(i_paddr);
    s_nxt.prdata = (i_psel && !i_pwrite) ? reg_read(i_paddr, s_r) : 32'h0000_0000;
    if (i_psel && i_penable && s_r.pready && i_pwrite && i_paddr == REG_TIMEOUT) begin
      if (i_pstrb[0]) begin
        s_nxt.tmo_set[7:0] = i_pwdata[7:0];
      end
      if (i_pstrb[1]) begin
        s_nxt.tmo_set[15:8] = i_pwdata[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s_r <= '0;
      s_r.st <= ST_INHIBIT;
      s_r.tmo_set <= TIMEOUT_RST;
      s_r.rg_reset <= 1'b1;
      s_r.rg_freeze <= 1'b1;
      s_r.decel <= DECEL_FASTEST;
      s_r.status[STS_SWON_DIS] <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_prdata = s_r.prdata;
  assign o_pready = s_r.pready;
  assign o_pslverr = s_r.pslverr;
  assign o_status_word = s_r.status;
  assign o_status_strobe = s_r.reply;
  assign o_pulse_enable = s_r.pulse_en;
  assign o_decel_mode = s_r.decel;
  assign o_rg_enable = s_r.rg_en;
  assign o_rg_reset = s_r.rg_reset;
  assign o_rg_freeze = s_r.rg_freeze;
  assign o_setpoint = s_r.sp_out;
  assign o_jog_cw = s_r.jog_cw;
  assign o_jog_ccw = s_r.jog_ccw;
  assign o_reverse_dir = s_r.reverse;
  assign o_data_set_sel = s_r.data_set;
  assign o_process_data_valid = s_r.pd_valid;
  assign o_telegram_fault = s_r.tmo_fault;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  zero_word_drop_a: assert property (i_telegram_valid && i_command_word == 16'h0000 |=> $stable(s_r.cmd))
    else $error("zero command word was latched");
  cmd_latch_a: assert property (accept |=> s_r.cmd == $past(i_command_word) ##1 o_status_strobe)
    else $error("command latch or status reply missing");
  coast_stop_a: assert property (!c_no_coast && !s_nxt.fault |=> !o_pulse_enable && o_status_word[STS_SWON_DIS])
    else $error("coast stop did not cut pulses");
  quick_priority_a: assert property (s_r.st == ST_OPERATING && c_no_coast && !c_no_quick && !s_nxt.fault
                                     |=> s_r.st == ST_QUICKSTOP && o_decel_mode == DECEL_FASTEST)
    else $error("quick stop lost priority");
  fault_hold_a: assert property (s_r.st == ST_FAULT && !s_r.ack_pulse |=> s_r.st == ST_FAULT)
    else $error("fault left without acknowledge edge");
  op_status_a: assert property (o_status_word[STS_OP_EN] |-> o_status_word[STS_READY] && !o_status_word[STS_FAULT])
    else $error("operation enabled with inconsistent status");
  timeout_raise_a: assert property (tmo_hit |=> o_telegram_fault && o_status_word[STS_FAULT])
    else $error("telegram timeout not flagged");
  timeout_off_a: assert property (s_r.tmo_set == 16'h0000 && !s_r.tmo_fault |=> !$rose(o_telegram_fault))
    else $error("disabled watchdog raised a fault");
  sp_gate_a: assert property (!s_r.cmd[CMD_SP_ENABLE] |=> o_setpoint == 16'h0000)
    else $error("inhibited setpoint passed through");
  ready_start_a: assert property (o_pulse_enable |-> !o_status_word[STS_READY_START])
    else $error("ready to start shown with pulses on");
  apb_answer_a: assert property (i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("apb answer not one cycle");
  ramp_down_a: assert property (s_r.st == ST_OPERATING && c_no_coast && c_no_quick && !c_on
                                && s_r.cmd[CMD_RG_ENABLE] && !s_nxt.fault
                                |=> s_r.st == ST_RAMPDOWN && o_decel_mode == DECEL_RAMP)
    else $error("ramp stop did not ramp down");
  rg_reset_a: assert property (!s_r.cmd[CMD_RG_ENABLE]
                               |=> o_rg_reset && !o_rg_enable && o_decel_mode == DECEL_FASTEST)
    else $error("ramp reset not forced");
  rg_freeze_a: assert property (!s_r.cmd[CMD_RG_RUN] |=> o_rg_freeze)
    else $error("ramp output not frozen");
  ack_clear_a: assert property (s_r.st == ST_FAULT && s_r.ack_pulse && !i_fault_active && !tmo_hit
                                |=> s_r.st == ST_INHIBIT && !o_status_word[STS_FAULT])
    else $error("acknowledge edge did not clear fault");
  jog_cw_run_a: assert property (s_r.st == ST_READY_START && c_no_coast && c_no_quick && !c_on
                                 && s_r.cmd[CMD_JOG_CW] && !s_r.cmd[CMD_JOG_CCW] && !s_nxt.fault
                                 |=> o_jog_cw && o_pulse_enable)
    else $error("clockwise jog not running");
  jog_ccw_run_a: assert property (s_r.st == ST_READY_START && c_no_coast && c_no_quick && !c_on
                                  && s_r.cmd[CMD_JOG_CCW] && !s_r.cmd[CMD_JOG_CW] && !s_nxt.fault
                                  |=> o_jog_ccw && o_pulse_enable)
    else $error("counter-clockwise jog not running");
  jog_brake_a: assert property (o_jog_cw && s_r.st == ST_READY_START && c_no_coast && c_no_quick && !c_on
                                && !s_r.cmd[CMD_JOG_CW] && !s_r.cmd[CMD_JOG_CCW] && !i_below_min_freq && !s_nxt.fault
                                |=> o_pulse_enable && o_decel_mode == DECEL_FASTEST)
    else $error("jog release did not brake");

endmodule

// File: tb/fieldbus_master.sv
// fieldbus master model: one command/setpoint telegram per call of send
// assumes the caller runs in the drive clock domain and calls send from procedural code
`timescale 1ns/1ps
module fieldbus_master (
  input wire logic i_mclk, // drive clock
  output logic o_telegram_valid, // one-cycle telegram strobe
  output logic [15:0] o_command_word, // command word
  output logic [15:0] o_setpoint_word // setpoint word
);
  initial begin
    o_telegram_valid = 1'b0;
    o_command_word = 16'h0000;
    o_setpoint_word = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // words only count with the strobe; between telegrams the lines carry the
  // inverse, so a design sampling stale words cannot match by luck
  task automatic send(input logic [15:0] cmd, input logic [15:0] sp);
    @(posedge i_mclk);
    o_telegram_valid <= 1'b1;
    o_command_word <= cmd;
    o_setpoint_word <= sp;
    @(posedge i_mclk);
    o_telegram_valid <= 1'b0;
    o_command_word <= ~cmd;
    o_setpoint_word <= ~sp;
  endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the drive command/status word interpreter
// assumes the fieldbus master model and a shortened millisecond count
`timescale 1ns/1ps
module tb;
  logic i_mclk, i_reset, i_supply_ok, i_init_done, i_fault_active, i_below_min_freq;
  logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr, err, tel_valid;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd, seed;
  logic [3:0] i_pstrb;
  logic [15:0] tel_cmd, tel_sp, o_status_word, o_setpoint, lat;
  logic o_status_strobe, o_pulse_enable, o_rg_enable, o_rg_reset, o_rg_freeze, o_jog_cw, o_jog_ccw;
  logic o_reverse_dir, o_data_set_sel, o_process_data_valid, o_telegram_fault;
  logic [1:0] o_decel_mode;
  logic [47:0] expq[$];
  logic [47:0] e;
  int error_cnt, checks_done;

  fieldbus_master u_fieldbus_master (.i_mclk(i_mclk), .o_telegram_valid(tel_valid),
    .o_command_word(tel_cmd), .o_setpoint_word(tel_sp));
  drive_control_status_word_logic #(.P_CYCLES_PER_MS(10)) u_drive_control_status_word_logic (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_telegram_valid(tel_valid), .i_command_word(tel_cmd),
    .i_setpoint_word(tel_sp), .i_supply_ok(i_supply_ok), .i_init_done(i_init_done),
    .i_fault_active(i_fault_active), .i_below_min_freq(i_below_min_freq), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_status_word(o_status_word), .o_status_strobe(o_status_strobe), .o_pulse_enable(o_pulse_enable),
    .o_decel_mode(o_decel_mode), .o_rg_enable(o_rg_enable), .o_rg_reset(o_rg_reset),
    .o_rg_freeze(o_rg_freeze), .o_setpoint(o_setpoint), .o_jog_cw(o_jog_cw), .o_jog_ccw(o_jog_ccw),
    .o_reverse_dir(o_reverse_dir), .o_data_set_sel(o_data_set_sel),
    .o_process_data_valid(o_process_data_valid), .o_telegram_fault(o_telegram_fault));

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  endfunction

  // setpoint latched only when the word claims valid process data
  task automatic tel(input logic [15:0] cmd, input logic [15:0] sp, input logic [15:0] st, input logic [15:0] m);
    logic [15:0] esp;
    if (cmd[10]) lat = sp;
    esp = cmd[6] ? (cmd[11] ? 16'h0000 - lat : lat) : 16'h0000;
    expq.push_back({m, st, esp});
    u_fieldbus_master.send(cmd, sp);
    repeat (8) @(posedge i_mclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    chk(o_pready, 1'b1, "pready");
    if (o_pready !== 1'b1) stop_test;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_mclk) begin
    if (o_status_strobe === 1'b1) begin
      if (expq.size() == 0) begin
        error_cnt++;
        $display("wrong value at %0t: status strobe with nothing sent", $time);
      end else begin
        e = expq.pop_front();
        chk(o_status_word & e[47:32], e[31:16] & e[47:32], "status word");
        chk(o_setpoint, e[15:0], "ramp setpoint");
      end
    end
  end

  initial begin
    #200000;
    error_cnt++;
    stop_test;
  end

  initial begin
    {i_reset, i_supply_ok, i_init_done, i_pstrb} = 7'h7F;
    {i_fault_active, i_below_min_freq, i_psel, i_penable, i_pwrite} = 5'h00;
    i_paddr = 12'h000;
    i_pwdata = 32'h0000_0000;
    {seed, lat, error_cnt, checks_done} = {32'h56D4, 16'h0000, 64'h0};
    repeat (16) @(posedge i_mclk);
    i_reset <= 1'b0;
    tel(16'h0406, 16'h0000, 16'h0031, 16'hFFFF);
    tel(16'h0407, 16'h0000, 16'h0033, 16'hFFFF);
    tel(16'h040F, 16'h0000, 16'h0036, 16'hFFFF);
    chk(o_pulse_enable, 1'b1, "pulses on");
    tel(16'h0C7F, 16'h1234, 16'h0036, 16'hFFFF);
    chk(o_reverse_dir, 1'b1, "reversed");
    tel(16'hF47F, 16'h0100, 16'h0036, 16'hFFFF);
    chk({o_data_set_sel, o_reverse_dir, o_process_data_valid}, 3'b101, "set select");
    tel(16'h007F, 16'h5555, 16'h0036, 16'hFFFF);
    chk(o_process_data_valid, 1'b0, "data invalid");
    tel(16'h044F, 16'h0200, 16'h0036, 16'hFFFF);
    chk({o_rg_enable, o_rg_reset, o_rg_freeze}, 3'b011, "ramp reset freeze");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      tel(16'h047F | {4'h0, seed[0], 11'h000}, seed[31:16], 16'h0036, 16'hFFFF);
    end
    tel(16'h047B, 16'h0000, 16'h0000, 16'h0020);
    chk(o_decel_mode, 2'h2, "quick stop");
    i_below_min_freq <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_below_min_freq <= 1'b0;
    chk(o_pulse_enable, 1'b0, "stopped");
    tel(16'h0406, 16'h0000, 16'h0031, 16'hFFFF);
    tel(16'h0407, 16'h0000, 16'h0033, 16'hFFFF);
    tel(16'h040F, 16'h0000, 16'h0036, 16'hFFFF);
    tel(16'h047E, 16'h0000, 16'h0000, 16'h0000);
    chk({o_decel_mode, o_pulse_enable}, 3'b011, "ramp down");
    i_below_min_freq <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_below_min_freq <= 1'b0;
    chk(o_pulse_enable, 1'b0, "pulses off");
    tel(16'h0506, 16'h0000, 16'h0000, 16'h0000);
    chk({o_jog_cw, o_jog_ccw}, 2'b10, "jog cw");
    tel(16'h0416, 16'h0000, 16'h0000, 16'h0000);
    chk({o_decel_mode, o_pulse_enable}, 3'b101, "jog brake");
    i_below_min_freq <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_below_min_freq <= 1'b0;
    tel(16'h0606, 16'h0000, 16'h0000, 16'h0000);
    chk({o_jog_cw, o_jog_ccw}, 2'b01, "jog ccw");
    tel(16'h0400, 16'h0000, 16'h0000, 16'h0010);
    chk(o_pulse_enable, 1'b0, "coast");
    i_fault_active <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_fault_active <= 1'b0;
    tel(16'h0406, 16'h0000, 16'h0039, 16'hFFFF);
    tel(16'h0486, 16'h0000, 16'h0071, 16'hFFFF);
    i_supply_ok <= 1'b0;
    tel(16'h0406, 16'h0000, 16'h0030, 16'hFFFF);
    i_supply_ok <= 1'b1;
    u_fieldbus_master.send(16'h0000, 16'h1111);
    repeat (8) @(posedge i_mclk);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0000_0406, "command reg");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[18:0], 19'h1_0031, "status reg");
    apb(1'b0, 12'h00C, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
    apb(1'b1, 12'h004, 32'h0000_FFFF);
    apb(1'b0, 12'h004, 32'h0);
    chk({err, rd[15:0]}, 17'h0_0031, "status ro");
    i_pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'hFFFF_1203);
    i_pstrb <= 4'hF;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_0003, "timeout reg");
    tel(16'h0406, 16'h0000, 16'h0031, 16'hFFFF);
    chk(o_telegram_fault, 1'b0, "no timeout yet");
    repeat (50) @(posedge i_mclk);
    chk(o_telegram_fault, 1'b1, "telegram timeout");
    chk(expq.size(), 32'h0, "replies missing");
    stop_test;
  end
endmodule
